// ===== hdl/power_state_defines.vh
// Constants of the power state event recorder: register indices,
// field positions, reset values and timing.
// Assumes inclusion by bare name from the design file.
`ifndef POWER_STATE_DEFINES_VH
`define POWER_STATE_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_POWER_STATE 16'h4003
`define IDX_ON_SOURCE 16'h400e
`define IDX_OFF_SOURCE 16'h400f
`define IDX_EVENT_CONFIG 16'h4020

// Power state register fields
`define BIT_CHIP_ON 15
`define BIT_CHIP_SLEEP 14

// On source register fields
`define BIT_TRANSITION_TYPE 15
`define BIT_WAKE_GPIO 11
`define BIT_WAKE_SUPPLY_LOW 10
`define BIT_WAKE_WATCHDOG 7
`define BIT_WAKE_SOFTWARE 6
`define BIT_WAKE_ALARM 5
`define BIT_WAKE_BUTTON 4
`define BIT_CAUSE_CONV_UV_RESET 3
`define BIT_CAUSE_SOFT_RESET 2
`define BIT_CAUSE_HARD_RESET 1
`define BIT_CAUSE_WDOG_RESET 0

// Off source register fields
`define BIT_OFF_REG_ERROR 13
`define BIT_OFF_SEQ_FAIL 12
`define BIT_OFF_GPIO 11
`define BIT_OFF_SUPPLY_LOW 10
`define BIT_OFF_OVERTEMP 9
`define BIT_OFF_SOFTWARE 6
`define BIT_OFF_BUTTON 4

// Event config register fields (low bit, width in comment)
`define CFG_GPIO_LSB 0
`define CFG_BUTTON_LSB 4
`define CFG_WDOG_LSB 8
`define CFG_SUPPLY_LSB 12
`define CFG_RESET 16'h0000

// Gpio modes (3 bits)
`define GPIO_NONE 3'h0
`define GPIO_ON 3'h1
`define GPIO_ON_OFF 3'h2
`define GPIO_SLEEP 3'h3
`define GPIO_SLEEP_WAKE 3'h4
// Button actions (2 bits)
`define BUTTON_ON 2'h1
`define BUTTON_OFF 2'h2
// Watchdog actions (2 bits)
`define WDOG_WAKE 2'h1
`define WDOG_RESET 2'h2
// Supply monitor actions (2 bits)
`define SUPPLY_WAKE 2'h1
`define SUPPLY_OFF 2'h2

`define SOURCE_RESET 16'h0000

// Timing
`define CLK_HZ 100000000
`define SEQ_TIMEOUT_S 2
`define SEQ_TIMEOUT_CYCLES (`SEQ_TIMEOUT_S * `CLK_HZ)

`endif

// ===== hdl/power_state_event_recorder.v
// Power state controller that records the cause of the newest on/wake
// and off transitions in two read-only source registers.
// Assumes an APB3 master on pclk and event pins from other domains.
//
// Overview of operation
// - Hardware reset sets on-source bit 1
// - Watchdog device reset sets on-source bit 0
// - Regulator error off sets off-source bit 13
// - Sequence failure off sets off-source bit 12
// - Gpio on/off request sets off-source bit 11
// - Supply low or shutdown sets off-source 10
// - Over-temperature shutdown sets off-source bit 9
// - Software chip-on clear sets off-source bit 6
// - Button off request sets off-source bit 4
// - Alarm in off: on, type plus alarm
// - Gpio on request: on, type plus gpio
// - Button on request: on, type plus button
// - Software sleep-bit clear wakes, software flag only
// - Watchdog wake config: wake, watchdog flag
// - Alarm in sleep: wake, alarm flag only
// - Gpio, supply, button wake set own flag
// - Reset causes off, recorded by reset flag
// - Shutdown always off; undervolt off when configured
// - Startup failure forces off as sequence failure
// - Software or gpio sleep request enters sleep
// - Source registers change only on new events
// - On sequence over two seconds forces off
// - Reset is off then on, recorded reset
// - Sleep leaves off source untouched
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "power_state_defines.vh"

module power_state_event_recorder #(
	parameter [31:0] SEQ_TIMEOUT_CYCLES = `SEQ_TIMEOUT_CYCLES
) (
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire ce,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Event pins, asynchronous levels, active high
	input wire rtc_alarm,
	input wire gpio_request,
	input wire button_request,
	input wire watchdog_timeout,
	input wire supply_below_low,
	input wire supply_below_shutdown,
	input wire overtemperature,
	input wire regulator_error,
	input wire hard_reset_request,
	input wire soft_reset_request,
	input wire converter_undervolt,
	input wire startup_failed,
	input wire sequence_done,
	// Power state outputs
	output reg chip_on,
	output reg chip_sleep,
	output reg sequence_run
);

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [3:0] ST_OFF = 4'h1;
	localparam [3:0] ST_SEQ = 4'h2;
	localparam [3:0] ST_ON = 4'h4;
	localparam [3:0] ST_SLEEP = 4'h8;
	localparam integer NPIN = 13;

	function [15:0] one_hot16;
		input [3:0] pos;
		begin
			one_hot16 = 16'h0001 << pos;
		end
	endfunction

	function addr_is;
		input [31:0] addr;
		input [15:0] idx;
		begin
			addr_is = (addr == {14'h0000, idx, 2'b00});
		end
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	reg [NPIN-1:0] pin_meta;
	reg [NPIN-1:0] pin_sync;
	reg [NPIN-1:0] pin_prev;
	wire [NPIN-1:0] pin_rise;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= {NPIN{1'b0}};
			pin_sync <= {NPIN{1'b0}};
			pin_prev <= {NPIN{1'b0}};
		end else if (ce) begin
			pin_meta <= {
				sequence_done,
				startup_failed,
				converter_undervolt,
				soft_reset_request,
				hard_reset_request,
				regulator_error,
				overtemperature,
				supply_below_shutdown,
				supply_below_low,
				watchdog_timeout,
				button_request,
				gpio_request,
				rtc_alarm
			};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Events act on assertion only, so a held level fires once
	assign pin_rise = pin_sync & ~pin_prev;
	wire ev_alarm = pin_rise[0];
	wire ev_gpio = pin_rise[1];
	wire ev_button = pin_rise[2];
	wire ev_wdog = pin_rise[3];
	wire ev_low = pin_rise[4];
	wire ev_shutdown = pin_rise[5];
	wire ev_hot = pin_rise[6];
	wire ev_reg_err = pin_rise[7];
	wire ev_hard_rst = pin_rise[8];
	wire ev_soft_rst = pin_rise[9];
	wire ev_conv_uv = pin_rise[10];
	wire ev_start_fail = pin_rise[11];
	wire seq_done_lvl = pin_sync[12];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [3:0] state;
	reg [3:0] next_state;
	reg [15:0] on_source;
	reg [15:0] next_on_source;
	reg [15:0] off_source;
	reg [15:0] next_off_source;
	reg [15:0] event_config;
	reg [31:0] seq_count;

	wire [2:0] gpio_mode = event_config[`CFG_GPIO_LSB +: 3];
	wire [1:0] button_act = event_config[`CFG_BUTTON_LSB +: 2];
	wire [1:0] wdog_act = event_config[`CFG_WDOG_LSB +: 2];
	wire [1:0] supply_act = event_config[`CFG_SUPPLY_LSB +: 2];

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Write takes effect on the completing edge only
	wire apb_done = psel & penable & pready;
	wire wr_done = apb_done & pwrite;
	wire wr_state = wr_done & addr_is(paddr, `IDX_POWER_STATE);
	wire wr_config = wr_done & addr_is(paddr, `IDX_EVENT_CONFIG);
	wire sw_off = wr_state & ~pwdata[`BIT_CHIP_ON];
	wire sw_sleep = wr_state & pwdata[`BIT_CHIP_ON] & pwdata[`BIT_CHIP_SLEEP];
	wire sw_wake = wr_state & pwdata[`BIT_CHIP_ON] & ~pwdata[`BIT_CHIP_SLEEP];

	// One below the limit, since the count starts at zero on entry
	wire seq_timeout = (state == ST_SEQ) && (seq_count >= SEQ_TIMEOUT_CYCLES - 32'd1);

	// ------------------------------------------------------------
	// Transition and cause selection
	// ------------------------------------------------------------
	// Priority: fault off causes, then resets, then software/button/gpio off, then sleep, then on/wake.
	// Only one event is recorded per cycle; lower ones are dropped.
	always @* begin
		next_state = state;
		next_on_source = on_source;
		next_off_source = off_source;
		// A corrupted state code falls back to off rather than hang
		if (state != ST_OFF && state != ST_SEQ && state != ST_ON
			&& state != ST_SLEEP) begin
			next_state = ST_OFF;
		end else if (state != ST_OFF) begin
			if (ev_reg_err) begin
				next_state = ST_OFF;
				next_off_source = one_hot16(`BIT_OFF_REG_ERROR);
			end else if (ev_start_fail || seq_timeout) begin
				next_state = ST_OFF;
				next_off_source = one_hot16(`BIT_OFF_SEQ_FAIL);
			end else if (ev_shutdown || (ev_low && supply_act == `SUPPLY_OFF)) begin
				next_state = ST_OFF;
				next_off_source = one_hot16(`BIT_OFF_SUPPLY_LOW);
			end else if (ev_hot) begin
				next_state = ST_OFF;
				next_off_source = one_hot16(`BIT_OFF_OVERTEMP);
			end else if (ev_hard_rst || ev_soft_rst || ev_conv_uv
				|| (ev_wdog && wdog_act == `WDOG_RESET)) begin
				// Off then straight back into the on sequence
				next_state = ST_SEQ;
				if (ev_hard_rst)
					next_on_source = one_hot16(`BIT_CAUSE_HARD_RESET);
				else if (ev_soft_rst)
					next_on_source = one_hot16(`BIT_CAUSE_SOFT_RESET);
				else if (ev_conv_uv)
					next_on_source = one_hot16(`BIT_CAUSE_CONV_UV_RESET);
				else
					next_on_source = one_hot16(`BIT_CAUSE_WDOG_RESET);
			end else if (sw_off) begin
				next_state = ST_OFF;
				next_off_source = one_hot16(`BIT_OFF_SOFTWARE);
			end else if (ev_button && button_act == `BUTTON_OFF) begin
				next_state = ST_OFF;
				next_off_source = one_hot16(`BIT_OFF_BUTTON);
			end else if (ev_gpio && gpio_mode == `GPIO_ON_OFF && state != ST_SEQ) begin
				next_state = ST_OFF;
				next_off_source = one_hot16(`BIT_OFF_GPIO);
			end else if (state == ST_ON) begin
				// Sleep leaves the off source alone
				if (sw_sleep || (ev_gpio && (gpio_mode == `GPIO_SLEEP
					|| gpio_mode == `GPIO_SLEEP_WAKE)))
					next_state = ST_SLEEP;
			end else if (state == ST_SLEEP) begin
				if (sw_wake) begin
					next_state = ST_ON;
					next_on_source = one_hot16(`BIT_WAKE_SOFTWARE);
				end else if (ev_wdog && wdog_act == `WDOG_WAKE) begin
					next_state = ST_ON;
					next_on_source = one_hot16(`BIT_WAKE_WATCHDOG);
				end else if (ev_alarm) begin
					next_state = ST_ON;
					next_on_source = one_hot16(`BIT_WAKE_ALARM);
				end else if (ev_gpio && gpio_mode == `GPIO_SLEEP_WAKE) begin
					next_state = ST_ON;
					next_on_source = one_hot16(`BIT_WAKE_GPIO);
				end else if (ev_low && supply_act == `SUPPLY_WAKE) begin
					next_state = ST_ON;
					next_on_source = one_hot16(`BIT_WAKE_SUPPLY_LOW);
				end else if (ev_button && button_act == `BUTTON_ON) begin
					next_state = ST_ON;
					next_on_source = one_hot16(`BIT_WAKE_BUTTON);
				end
			end else if (seq_done_lvl) begin
				next_state = ST_ON;
			end
		end else begin
			if (ev_alarm) begin
				next_state = ST_SEQ;
				next_on_source = one_hot16(`BIT_TRANSITION_TYPE)
					| one_hot16(`BIT_WAKE_ALARM);
			end else if (ev_gpio && (gpio_mode == `GPIO_ON
				|| gpio_mode == `GPIO_ON_OFF)) begin
				next_state = ST_SEQ;
				next_on_source = one_hot16(`BIT_TRANSITION_TYPE)
					| one_hot16(`BIT_WAKE_GPIO);
			end else if (ev_button && button_act == `BUTTON_ON) begin
				next_state = ST_SEQ;
				next_on_source = one_hot16(`BIT_TRANSITION_TYPE)
					| one_hot16(`BIT_WAKE_BUTTON);
			end
		end
	end

	// ------------------------------------------------------------
	// State, sources and sequence timer
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_OFF;
			on_source <= `SOURCE_RESET;
			off_source <= `SOURCE_RESET;
			seq_count <= 32'h00000000;
			chip_on <= 1'b0;
			chip_sleep <= 1'b0;
			sequence_run <= 1'b0;
		end else if (ce) begin
			// Outputs follow next_state so they stay in step with state
			case (next_state)
				ST_OFF: begin
					chip_on <= 1'b0;
					chip_sleep <= 1'b0;
					sequence_run <= 1'b0;
				end
				ST_SEQ: begin
					chip_on <= 1'b1;
					chip_sleep <= 1'b0;
					sequence_run <= 1'b1;
				end
				ST_ON: begin
					chip_on <= 1'b1;
					chip_sleep <= 1'b0;
					sequence_run <= 1'b0;
				end
				ST_SLEEP: begin
					chip_on <= 1'b1;
					chip_sleep <= 1'b1;
					sequence_run <= 1'b0;
				end
				default: begin
					// Unreachable codes drive the off outputs
					chip_on <= 1'b0;
					chip_sleep <= 1'b0;
					sequence_run <= 1'b0;
				end
			endcase
			state <= next_state;
			// Sources only move when an event selected a new value
			on_source <= next_on_source;
			off_source <= next_off_source;
			// Timer restarts on every entry, and on a reset in the sequence that changes the on source
			if (next_state == ST_SEQ && state != ST_SEQ)
				seq_count <= 32'h00000000;
			else if (next_state == ST_SEQ && next_on_source != on_source)
				seq_count <= 32'h00000000;
			else if (state == ST_SEQ)
				seq_count <= seq_count + 32'd1;
		end
	end

	// ------------------------------------------------------------
	// APB slave, one wait state per transfer
	// ------------------------------------------------------------
	reg [31:0] read_mux;
	reg read_ok;

	always @* begin
		read_mux = 32'h00000000;
		read_ok = 1'b1;
		// Upper halves read zero; registers are 16 bits wide
		if (addr_is(paddr, `IDX_POWER_STATE))
			read_mux = {16'h0000, chip_on, chip_sleep, 14'h0000};
		else if (addr_is(paddr, `IDX_ON_SOURCE))
			read_mux = {16'h0000, on_source};
		else if (addr_is(paddr, `IDX_OFF_SOURCE))
			read_mux = {16'h0000, off_source};
		else if (addr_is(paddr, `IDX_EVENT_CONFIG))
			read_mux = {16'h0000, event_config};
		else
			read_ok = 1'b0;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			event_config <= `CFG_RESET;
		end else if (ce) begin
			if (psel && penable && !pready) begin
				pready <= 1'b1;
				// Source registers are read-only: a write there errors
				pslverr <= !read_ok || (pwrite
					&& (addr_is(paddr, `IDX_ON_SOURCE)
					|| addr_is(paddr, `IDX_OFF_SOURCE)));
				prdata <= pwrite ? 32'h00000000 : read_mux;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
			// Config writes are taken in every power state
			if (wr_config)
				event_config <= pwdata[15:0];
		end
	end

endmodule

// ===== verification/power_state_event_recorder_props.sv
// Checker of state outputs against event pins and APB answer timing.
// Assumes a bind onto the recorder, timeout parameter passed down.
`timescale 1ns/1ps
module power_state_event_recorder_props #(
	parameter [31:0] SEQ_TIMEOUT_CYCLES = 32'd50
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Bus answer
	input wire pready,
	input wire pslverr,
	// Event pins
	input wire rtc_alarm,
	input wire supply_below_shutdown,
	input wire overtemperature,
	input wire regulator_error,
	input wire startup_failed,
	// Power state
	input wire chip_on,
	input wire chip_sleep,
	input wire sequence_run
);
	int run_len;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// Properties
	// ----
	// Counter, since the timeout is far beyond a repetition
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_len <= 0;
		else
			run_len <= sequence_run ? run_len + 1 : 0;
	end
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held over one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_sleep_on: assert property (chip_sleep |-> chip_on)
		else $error("sleep while off");
	chk_seq_bound: assert property (run_len <= SEQ_TIMEOUT_CYCLES + 8)
		else $error("sequence ran past timeout");
	chk_alarm_on: assert property ($rose(rtc_alarm) && !chip_on |-> ##[2:5] sequence_run)
		else $error("alarm in off started no sequence");
	chk_alarm_wake: assert property ($rose(rtc_alarm) && chip_sleep |-> ##[2:5]
		(chip_on && !chip_sleep)) else $error("alarm in sleep did not wake");
	chk_regerr_off: assert property ($rose(regulator_error) && chip_on |-> ##[2:5] !chip_on)
		else $error("regulator error did not force off");
	chk_shut_off: assert property ($rose(supply_below_shutdown) && chip_on |-> ##[2:5] !chip_on)
		else $error("shutdown level did not force off");
	chk_heat_off: assert property ($rose(overtemperature) && chip_on |-> ##[2:5] !chip_on)
		else $error("overtemperature did not force off");
	chk_fail_off: assert property ($rose(startup_failed) && sequence_run |-> ##[2:5] !chip_on)
		else $error("startup failure did not force off");
endmodule
bind power_state_event_recorder power_state_event_recorder_props #(
	.SEQ_TIMEOUT_CYCLES(SEQ_TIMEOUT_CYCLES)) props (.pclk(pclk), .presetn(presetn),
	.pready(pready), .pslverr(pslverr), .rtc_alarm(rtc_alarm),
	.supply_below_shutdown(supply_below_shutdown), .overtemperature(overtemperature),
	.regulator_error(regulator_error), .startup_failed(startup_failed), .chip_on(chip_on),
	.chip_sleep(chip_sleep), .sequence_run(sequence_run));

// ===== verification/event_source_model.sv
// Event sources and converter sequencer seen by the recorder.
// Assumes pclk; pulses are edges held long enough for the synchroniser.
`timescale 1ns/1ps
module event_source_model (
	// Clock and state
	input wire pclk,
	input wire sequence_run,
	// Event pins and sequence completion
	output logic [11:0] ev,
	output logic sequence_done
);
	int done_delay = 2;
	int cnt = 0;
	initial begin
		ev = 12'h000;
		sequence_done = 1'b0;
	end
	// A huge delay never completes, so the timeout can be reached
	always @(posedge pclk) begin
		cnt <= sequence_run ? cnt + 1 : 0;
		sequence_done <= sequence_run && cnt >= done_delay;
	end
	task pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		repeat (4) @(posedge pclk);
		ev[i] <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
endmodule

// ===== verification/power_state_event_recorder_bench.sv
// Self-checking bench: random events against a reference model.
// Assumes the recorder, its defines header and the event source model.
`timescale 1ns/1ps
`include "power_state_defines.vh"
module power_state_event_recorder_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, chip_on, chip_sleep, sequence_run, sequence_done, er;
	logic [11:0] ev;
	int n_errors = 0, n_checks = 0, st = 0, eon = 0, eoff = 0, gm, bm, wm, sm, i;
	always #5 pclk = ~pclk;
	event_source_model src (.pclk(pclk), .sequence_run(sequence_run), .ev(ev),
		.sequence_done(sequence_done));
	power_state_event_recorder #(.SEQ_TIMEOUT_CYCLES(50)) DUT (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rtc_alarm(ev[0]), .gpio_request(ev[1]), .button_request(ev[2]),
		.watchdog_timeout(ev[3]), .supply_below_low(ev[4]), .supply_below_shutdown(ev[5]),
		.overtemperature(ev[6]), .regulator_error(ev[7]), .hard_reset_request(ev[8]),
		.soft_reset_request(ev[9]), .converter_undervolt(ev[10]), .startup_failed(ev[11]),
		.sequence_done(sequence_done), .chip_on(chip_on), .chip_sleep(chip_sleep),
		.sequence_run(sequence_run));
	// ----
	// Tasks
	// ----
	task end_sim;
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {14'h0, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task check_all;
		apb(1'b0, `IDX_ON_SOURCE, 32'h0);
		check("on_source", rd, eon);
		apb(1'b0, `IDX_OFF_SOURCE, 32'h0);
		check("off_source", rd, eoff);
		apb(1'b0, `IDX_POWER_STATE, 32'h0);
		check("state_bits", rd[15:14], {st != 0, st == 2});
		check("chip_sleep", chip_sleep, st == 2);
		check("chip_on", chip_on, st != 0);
	endtask
	// Reference: on/wake sets on source, off sets off source
	task fire(input int i);
		if (i < 12)
			src.pulse(i);
		else
			apb(1'b1, `IDX_POWER_STATE, i == 12 ? 32'h0 : (i == 13 ? 32'hc000 : 32'h8000));
		case (i)
			0: if (st != 1) {eon, st} = {st == 0 ? 32'h8020 : 32'h0020, 32'd1};
			1: if (st == 0 && (gm == 1 || gm == 2)) {eon, st} = {32'h8800, 32'd1};
				else if (st != 0 && gm == 2) {eoff, st} = {32'h0800, 32'd0};
				else if (st == 1 && gm > 2) st = 2;
				else if (st == 2 && gm == 4) {eon, st} = {32'h0800, 32'd1};
			2: if (bm == 1 && st != 1) {eon, st} = {st ? 32'h0010 : 32'h8010, 32'd1};
				else if (bm == 2 && st != 0) {eoff, st} = {32'h0010, 32'd0};
			3: if (wm == 1 && st == 2) {eon, st} = {32'h0080, 32'd1};
				else if (wm == 2 && st != 0) {eon, st} = {32'h0001, 32'd1};
			4: if (sm == 1 && st == 2) {eon, st} = {32'h0400, 32'd1};
				else if (sm == 2 && st != 0) {eoff, st} = {32'h0400, 32'd0};
			5: if (st) {eoff, st} = {32'h0400, 32'd0};
			6: if (st) {eoff, st} = {32'h0200, 32'd0};
			7: if (st) {eoff, st} = {32'h2000, 32'd0};
			8, 9, 10: if (st) {eon, st} = {32'h0001 << (i - 7), 32'd1};
			11: if (st) {eoff, st} = {32'h1000, 32'd0};
			12: if (st) {eoff, st} = {32'h0040, 32'd0};
			13: if (st == 1) st = 2;
			14: if (st == 2) {eon, st} = {16'h0040, 32'd1};
		endcase
		repeat (20) @(posedge pclk);
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		void'($urandom(10346));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		check_all;
		apb(1'b0, 16'h4001, 32'h0);
		check("unmapped_err", er, 1'b1);
		apb(1'b1, `IDX_OFF_SOURCE, 32'hffff);
		check("ro_write_err", er, 1'b1);
		for (int n = 0; n < 60; n++) begin
			if (n % 8 == 0) begin
				gm = $urandom % 5;
				bm = $urandom % 3;
				wm = $urandom % 3;
				sm = $urandom % 3;
				apb(1'b1, `IDX_EVENT_CONFIG, (sm << 12) | (wm << 8) | (bm << 4) | gm);
			end
			i = $urandom % 14;
			i = i >= 11 ? i + 1 : i;
			// Watchdog and reset pins are ignored in off, so an alarm is sent there instead
			if (st == 0 && (i == 3 || (i >= 8 && i <= 10)))
				i = 0;
			fire(i);
			check_all;
		end
		if (st == 0)
			fire(0);
		fire(12);
		src.done_delay = 1000;
		fire(0);
		repeat (60) @(posedge pclk);
		{eoff, st} = {32'h1000, 32'd0};
		check_all;
		fire(0);
		fire(12);
		fire(0);
		fire(11);
		check_all;
		end_sim;
	end
	initial begin
		#100000;
		n_errors++;
		end_sim;
	end
endmodule
